/* File: inc/pmc_params.svh */
/*
  Constants of the power mode controller: register offsets, field
  positions, reset values and resume timing.
  Assumes a 125 MHz system clock and a 32-bit classic Wishbone bus.
*/
// What this block does
// - active template enables each subsystem individually
// - disabled subsystem gets its clocks gated
// - alternate active applies its own template
// - sleep gates all, keeps low-speed and timers
// - hibernate stops clocks, wakes on pins only
// - low modes entered only by register write
// - wakeup from enabled interrupt or device reset
// - reset sources; hibernate accepts external pin only
// - any wakeup returns active with cpu enabled
// - cpu disabled by template, re-enabled on wake
// - active mode is the default after boot
// - sleep resume completes under fifteen microseconds
// - hibernate resume completes under hundred microseconds
// - hibernate holds pin outputs and interrupt setup
// - timewheel interrupts can wake from sleep
// - modes ordered by decreasing power consumption
// - external reset pin is active low
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define PMC_ADR_MODE     8'h00
`define PMC_ADR_ACT_TPL  8'h04
`define PMC_ADR_ALT_TPL  8'h08
`define PMC_ADR_WAKE_EN  8'h0C
`define PMC_ADR_STAT     8'h10
`define PMC_ADR_CLR      8'h14
`define PMC_ADR_IRQ_EN   8'h18
`define PMC_ADR_STATUS   8'h1C

`define PMC_NSUB         8
`define PMC_NWAKE        6
`define PMC_NEVT         3
`define PMC_BIT_CPU      0
`define PMC_WK_PORT      1
`define PMC_EV_WAKE      0
`define PMC_EV_RESET     1
`define PMC_EV_REJECT    2

`define PMC_ACT_TPL_RST  8'hFF
`define PMC_ALT_TPL_RST  8'hFE
`define PMC_WAKE_EN_RST  6'h3F

`define PMC_CLK_NS       8
`define PMC_SLP_NS       15000
`define PMC_HIB_NS       100000
`define PMC_SLP_CYC      ((`PMC_SLP_NS) / (`PMC_CLK_NS))
`define PMC_HIB_CYC      ((`PMC_HIB_NS) / (`PMC_CLK_NS))
`define PMC_CNT_W        14

`endif

/* File: inc/pmc_pkg.sv */
/*
  Types of the power mode controller.
  Assumes nothing beyond the params header for widths.
*/
package pmc_pkg;
  // ordered by decreasing consumption
  typedef enum logic [1:0] {
    PMC_ACTIVE = 2'b00,
    PMC_ALT    = 2'b01,
    PMC_SLEEP  = 2'b10,
    PMC_HIB    = 2'b11
  } pmc_mode_e;
endpackage

/* File: hw/pmc_top.sv */
/*
  Global power mode controller: mode state, template clock gating,
  wakeup and reset handling, resume timers, Wishbone register slave
  and interrupt. Assumes wake and reset inputs synchronous to mclk and
  the external reset pin already filtered.
*/
`include "pmc_params.svh"

module pmc_top #(
  parameter int HIB_CYC = `PMC_HIB_CYC
) (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      cmp_wake,
  input  wire logic                      port_interrupt_unit,
  input  wire logic                      i2c_wake,
  input  wire logic                      rtc_wake,
  input  wire logic                      central_timewheel,
  input  wire logic                      low_voltage_detect,
  input  wire logic                      external_reset_pin_n,
  input  wire logic                      watchdog_reset_source,
  input  wire logic                      precision_reset,
  output logic      [`PMC_NSUB-1:0]      sub_clk_en,
  output logic                           cpu_en,
  output logic                           lowspeed_clk_en,
  output logic                           pin_hold,
  output pmc_pkg::pmc_mode_e             cur_mode,
  output logic                           resuming,
  output logic                           irq
);
  import pmc_pkg::*;

  // ==========================================================
  // declarations
  logic [`PMC_NSUB-1:0]  act_tpl;
  logic [`PMC_NSUB-1:0]  alt_tpl;
  logic [`PMC_NWAKE-1:0] wake_en;
  logic [`PMC_NEVT-1:0]  stat;
  logic [`PMC_NEVT-1:0]  irq_en;
  logic [`PMC_CNT_W-1:0] rcnt;
  logic [`PMC_NWAKE-1:0] wake_src;
  logic [`PMC_NWAKE-1:0] wake_hit;
  logic                  wake;
  logic                  dev_reset;
  logic                  wb_req;
  logic                  wb_wr;
  logic                  mode_wr;
  logic                  req_ok;
  logic                  resume_done;
  logic [`PMC_NEVT-1:0]  next_stat;
  pmc_mode_e             req_mode;

  // the wake sampling edge, the return edge and the clock gate register
  // add three cycles, so the load keeps them inside the resume bound
  localparam logic [`PMC_CNT_W-1:0] SLP_LOAD =
    `PMC_CNT_W'(`PMC_SLP_CYC - 4);
  localparam logic [`PMC_CNT_W-1:0] HIB_LOAD =
    `PMC_CNT_W'(HIB_CYC - 4);

  // ==========================================================
  // wakeup and reset qualification
  assign wake_src = {low_voltage_detect, central_timewheel, rtc_wake,
                     i2c_wake, port_interrupt_unit, cmp_wake};

  always_comb begin
    wake_hit = wake_src & wake_en;
    if (cur_mode == PMC_HIB) begin
      // only port pins can reach a hibernating core
      wake_hit = wake_hit & `PMC_NWAKE'(1 << `PMC_WK_PORT);
    end
  end

  // timewheel is one of the sources seen in sleep
  assign wake = |wake_hit;

  // in hibernate the watchdog and precision reset are unpowered
  assign dev_reset = !external_reset_pin_n ||
                     ((cur_mode != PMC_HIB) &&
                      (watchdog_reset_source || precision_reset));

  // ==========================================================
  // bus decode
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
  assign mode_wr = wb_wr && (wb_adr_i == `PMC_ADR_MODE);
  assign req_mode = pmc_mode_e'(wb_dat_i[1:0]);
  // a request during a resume is dropped
  assign req_ok  = mode_wr && !resuming;
  assign resume_done = resuming && (rcnt == '0);

  // ==========================================================
  // mode state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cur_mode <= PMC_ACTIVE;
      resuming <= 1'b0;
      rcnt     <= '0;
    end else if (dev_reset) begin
      cur_mode <= PMC_ACTIVE;
      resuming <= 1'b0;
      rcnt     <= '0;
    end else if (resuming) begin
      if (resume_done) begin
        cur_mode <= PMC_ACTIVE;
        resuming <= 1'b0;
      end else begin
        rcnt <= rcnt - 1'b1;
      end
    end else begin
      case (cur_mode)
        PMC_SLEEP: begin
          if (wake) begin
            resuming <= 1'b1;
            rcnt     <= SLP_LOAD;
          end
        end
        PMC_HIB: begin
          if (wake) begin
            resuming <= 1'b1;
            rcnt     <= HIB_LOAD;
          end
        end
        PMC_ALT: begin
          if (wake) begin
            cur_mode <= PMC_ACTIVE;
          end else if (req_ok) begin
            cur_mode <= req_mode;
          end
        end
        PMC_ACTIVE: begin
          if (req_ok && !wake) begin
            cur_mode <= req_mode;
          end
        end
        default: begin
          cur_mode <= PMC_ACTIVE;
        end
      endcase
    end
  end

  // ==========================================================
  // templates and wake enables
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      act_tpl <= `PMC_ACT_TPL_RST;
      alt_tpl <= `PMC_ALT_TPL_RST;
      wake_en <= `PMC_WAKE_EN_RST;
    end else if (dev_reset) begin
      act_tpl <= `PMC_ACT_TPL_RST;
      alt_tpl <= `PMC_ALT_TPL_RST;
      wake_en <= `PMC_WAKE_EN_RST;
    end else begin
      if (wb_wr && wb_adr_i == `PMC_ADR_ACT_TPL) begin
        act_tpl <= wb_dat_i[`PMC_NSUB-1:0];
      end
      if (wb_wr && wb_adr_i == `PMC_ADR_ALT_TPL) begin
        alt_tpl <= wb_dat_i[`PMC_NSUB-1:0];
      end
      if (wb_wr && wb_adr_i == `PMC_ADR_WAKE_EN) begin
        wake_en <= wb_dat_i[`PMC_NWAKE-1:0];
      end
      // hardware re-enable beats a firmware write in the same cycle
      if (resume_done || (wake && !resuming &&
          (cur_mode == PMC_ACTIVE || cur_mode == PMC_ALT))) begin
        act_tpl[`PMC_BIT_CPU] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // clock gating outputs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sub_clk_en      <= '0;
      lowspeed_clk_en <= 1'b1;
      pin_hold        <= 1'b0;
    end else begin
      if (resuming) begin
        sub_clk_en <= '0;
      end else begin
        case (cur_mode)
          PMC_ACTIVE: sub_clk_en <= act_tpl;
          PMC_ALT:    sub_clk_en <= alt_tpl;
          PMC_SLEEP:  sub_clk_en <= '0;
          PMC_HIB:    sub_clk_en <= '0;
          default:    sub_clk_en <= '0;
        endcase
      end
      // sleep keeps low-speed clock for rtc and timewheel
      lowspeed_clk_en <= (cur_mode != PMC_HIB);
      // outputs and pin interrupt setup frozen while hibernating
      pin_hold <= (cur_mode == PMC_HIB);
    end
  end

  // gated clock follows the template bit
  assign cpu_en = sub_clk_en[`PMC_BIT_CPU];

  // ==========================================================
  // interrupt status
  always_comb begin
    next_stat = stat;
    if (wb_wr && wb_adr_i == `PMC_ADR_CLR) begin
      next_stat = next_stat & ~wb_dat_i[`PMC_NEVT-1:0];
    end
    // set wins over clear
    if (resume_done) begin
      next_stat[`PMC_EV_WAKE] = 1'b1;
    end
    if (dev_reset) begin
      next_stat[`PMC_EV_RESET] = 1'b1;
    end
    if (mode_wr && resuming) begin
      next_stat[`PMC_EV_REJECT] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stat   <= '0;
      irq_en <= '0;
      irq    <= 1'b0;
    end else begin
      stat <= next_stat;
      if (wb_wr && wb_adr_i == `PMC_ADR_IRQ_EN) begin
        irq_en <= wb_dat_i[`PMC_NEVT-1:0];
      end
      irq <= |(next_stat & irq_en);
    end
  end

  // ==========================================================
  // wishbone slave: ack one cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `PMC_ADR_MODE:    wb_dat_o <= {30'h0, cur_mode};
          `PMC_ADR_ACT_TPL: wb_dat_o <= {24'h0, act_tpl};
          `PMC_ADR_ALT_TPL: wb_dat_o <= {24'h0, alt_tpl};
          `PMC_ADR_WAKE_EN: wb_dat_o <= {26'h0, wake_en};
          `PMC_ADR_STAT:    wb_dat_o <= {29'h0, stat};
          `PMC_ADR_IRQ_EN:  wb_dat_o <= {29'h0, irq_en};
          `PMC_ADR_STATUS:  wb_dat_o <= {15'h0, resuming,
                                         2'h0, rcnt};
          default:          wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_sleep_wake;
    cur_mode == PMC_SLEEP && !resuming && wake && !dev_reset;
  endsequence

  sequence s_resume_end;
    resuming && rcnt == '0 && !dev_reset;
  endsequence

  a_sleep_resume_len: assert property (
    s_sleep_wake |=> resuming && rcnt == SLP_LOAD)
    else $error("sleep resume not loaded with sleep count");

  a_hib_resume_len: assert property (
    cur_mode == PMC_HIB && !resuming && wake && !dev_reset
    |=> resuming && rcnt == HIB_LOAD)
    else $error("hibernate resume not loaded with hib count");

  a_resume_to_active: assert property (
    s_resume_end |=> cur_mode == PMC_ACTIVE && !resuming
                     && act_tpl[`PMC_BIT_CPU] ##1 cpu_en)
    else $error("resume did not return active with cpu on");

  a_hib_port_only: assert property (
    cur_mode == PMC_HIB && !resuming && !port_interrupt_unit
    && external_reset_pin_n |=> cur_mode == PMC_HIB && !resuming)
    else $error("hibernate left without port interrupt");

  a_sleep_gated: assert property (
    cur_mode == PMC_SLEEP ##1 cur_mode == PMC_SLEEP
    |-> sub_clk_en == '0 && lowspeed_clk_en)
    else $error("sleep left clocks running");

  a_hib_hold: assert property (
    cur_mode == PMC_HIB ##1 cur_mode == PMC_HIB
    |-> pin_hold && !lowspeed_clk_en)
    else $error("hibernate lost pin hold or clock stop");

  a_active_tpl: assert property (
    cur_mode == PMC_ACTIVE && !resuming |=> sub_clk_en == $past(act_tpl))
    else $error("active clocks differ from template");

  a_alt_tpl: assert property (
    cur_mode == PMC_ALT && !resuming |=> sub_clk_en == $past(alt_tpl))
    else $error("alternate clocks differ from template");

  a_req_ignored: assert property (
    resuming && !resume_done && !dev_reset |=> $stable(cur_mode))
    else $error("mode changed during resume");

  a_ext_reset: assert property (
    !external_reset_pin_n |=> cur_mode == PMC_ACTIVE && !resuming
                              && stat[`PMC_EV_RESET])
    else $error("external reset did not force active");

  a_stat_set_wins: assert property (
    dev_reset && wb_wr && wb_adr_i == `PMC_ADR_CLR
    |=> stat[`PMC_EV_RESET])
    else $error("reset event lost against clear");

  // only a bus write may take the core out of active
  a_active_stays: assert property (
    cur_mode == PMC_ACTIVE && !resuming && !mode_wr && !dev_reset
    |=> cur_mode == PMC_ACTIVE)
    else $error("active left without a mode write");

  a_ctw_wakes: assert property (
    cur_mode == PMC_SLEEP && !resuming && central_timewheel
    && wake_en[4] && !dev_reset |=> resuming)
    else $error("timewheel did not wake sleeping core");

  // watchdog and precision reset are unpowered in hibernate
  a_hib_rst_mask: assert property (
    cur_mode == PMC_HIB && external_reset_pin_n
    && !stat[`PMC_EV_RESET] |=> !stat[`PMC_EV_RESET])
    else $error("internal reset reached hibernating core");

endmodule

/* File: tb/pmc_wake_model.sv */
/*
  Wake and reset source model: drives the event inputs of the power
  mode controller. Assumes the bench calls pulse() between edges.
*/
module pmc_wake_model (
  input  wire logic       mclk,
  output logic      [7:0] src,
  output logic            ext_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin_low;
  initial begin
    src = 8'h00;
    pin_low = 1'b0;
  end
  // undriven pin floats high through its pull-up
  assign ext_rst_n = ~pin_low;
  // 0..7 sources, 8 reset pin; one-cycle request, then released
  task automatic pulse(input int i);
    @(posedge mclk);
    if (i == 8) begin
      pin_low <= 1'b1;
    end else begin
      src[i] <= 1'b1;
    end
    @(posedge mclk);
    pin_low <= 1'b0;
    src <= 8'h00;
  endtask
endmodule

/* File: tb/tb.sv */
/*
  Self-checking bench of the power mode controller.
  Assumes the wake source model and a shortened hibernate count.
*/
`include "pmc_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;
  localparam int HIB = 20;
  logic mclk, rstn, cyc, stb, we, ack, ext_rst_n;
  logic [7:0] adr, src, sub_clk_en, act, alt;
  logic [3:0] sel;
  logic [31:0] dat, rdat, q;
  logic cpu_en, ls_en, pin_hold, resuming, irq;
  pmc_mode_e cur_mode;
  int mismatches, check_count, i, n;
  time t0;
  always #4 mclk = ~mclk;
  pmc_wake_model wk_u (.mclk(mclk), .src(src), .ext_rst_n(ext_rst_n));
  pmc_top #(.HIB_CYC(HIB)) dut_u (
    .mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_wake(src[0]),
    .port_interrupt_unit(src[1]), .i2c_wake(src[2]), .rtc_wake(src[3]),
    .central_timewheel(src[4]), .low_voltage_detect(src[5]),
    .external_reset_pin_n(ext_rst_n), .watchdog_reset_source(src[6]),
    .precision_reset(src[7]), .sub_clk_en(sub_clk_en), .cpu_en(cpu_en),
    .lowspeed_clk_en(ls_en), .pin_hold(pin_hold), .cur_mode(cur_mode),
    .resuming(resuming), .irq(irq));
  // ==========================================
  // helpers
  function automatic logic [31:0] exp_clk(input pmc_mode_e m);
    return (m == PMC_ACTIVE) ? act : (m == PMC_ALT) ? alt : 32'h0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) chk("wb_ack_o", 32'h1, 32'h0);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // settles mode, then the clock enables one edge later
  task automatic wait_mode(input pmc_mode_e m, input int lim);
    n = 0;
    while (cur_mode !== m && n < lim) begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
    chk("cur_mode", {30'h0, m}, {30'h0, cur_mode});
    chk("sub_clk_en", exp_clk(m), {24'h0, sub_clk_en});
  endtask
  task automatic give_verdict;
    $display("TB: %0d checks, %0d mismatches", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial begin
    #(30000 * 8);
    mismatches++;
    give_verdict();
  end
  // ==========================================
  // tests
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    {cyc, stb, we, adr, dat} = '0;
    sel = 4'hF;
    mismatches = 0;
    check_count = 0;
    act = 8'hFF;
    void'($urandom(32'hC0A713F1));
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    wait_mode(PMC_ACTIVE, 2);
    rd_chk("act_tpl", `PMC_ADR_ACT_TPL, 32'hFF);
    rd_chk("alt_tpl", `PMC_ADR_ALT_TPL, 32'hFE);
    rd_chk("wake_en", `PMC_ADR_WAKE_EN, 32'h3F);
    rd_chk("irq_en", `PMC_ADR_IRQ_EN, 32'h0);
    rd_chk("mode", `PMC_ADR_MODE, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    $display("TB: reset test done");
    for (i = 0; i < 4; i++) begin
      act = 8'($urandom);
      act[0] = ~i[0];
      wb(1'b1, `PMC_ADR_ACT_TPL, {24'h0, act});
      wait_mode(PMC_ACTIVE, 2);
      chk("cpu_en", {31'h0, act[0]}, {31'h0, cpu_en});
    end
    alt = 8'($urandom);
    wb(1'b1, `PMC_ADR_ALT_TPL, {24'h0, alt});
    wb(1'b1, `PMC_ADR_MODE, 32'h1);
    wait_mode(PMC_ALT, 10);
    wk_u.pulse(0);
    act[0] = 1'b1;
    wait_mode(PMC_ACTIVE, 10);
    chk("cpu_en", 32'h1, {31'h0, cpu_en});
    $display("TB: template test done");
    wb(1'b1, `PMC_ADR_CLR, 32'h7);
    wb(1'b1, `PMC_ADR_MODE, 32'h2);
    wait_mode(PMC_SLEEP, 10);
    chk("lowspeed", 32'h1, {31'h0, ls_en});
    wk_u.pulse(4);
    // the wake input rose one cycle before the task returned
    t0 = $time - 8;
    wb(1'b1, `PMC_ADR_MODE, 32'h1);
    chk("resuming", 32'h1, {31'h0, resuming});
    wb(1'b0, `PMC_ADR_STATUS, 32'h0);
    chk("status_busy", 32'h10000, q & 32'h10000);
    wait_mode(PMC_ACTIVE, 2000);
    // wait_mode returns two edges after it first saw active
    chk("sleep_fast", 32'h1, {31'h0, ($time - t0 - 16) < `PMC_SLP_NS});
    rd_chk("stat", `PMC_ADR_STAT, 32'h5);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wb(1'b1, `PMC_ADR_IRQ_EN, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, `PMC_ADR_CLR, 32'h7);
    repeat (2) @(posedge mclk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    $display("TB: sleep test done");
    wb(1'b1, `PMC_ADR_WAKE_EN, 32'h3E);
    wb(1'b1, `PMC_ADR_MODE, 32'h2);
    wait_mode(PMC_SLEEP, 10);
    wk_u.pulse(0);
    wait_mode(PMC_SLEEP, 5);
    wk_u.pulse(2);
    wait_mode(PMC_ACTIVE, 2000);
    wb(1'b1, `PMC_ADR_MODE, 32'h3);
    wait_mode(PMC_HIB, 10);
    chk("pin_hold", 32'h1, {31'h0, pin_hold});
    chk("lowspeed", 32'h0, {31'h0, ls_en});
    for (i = 2; i < 8; i++) wk_u.pulse(i);
    wait_mode(PMC_HIB, 5);
    wk_u.pulse(1);
    t0 = $time - 8;
    wait_mode(PMC_ACTIVE, HIB + 10);
    chk("hib_fast", 32'h1, {31'h0, ($time - t0 - 16) < HIB * 8});
    chk("pin_free", 32'h0, {31'h0, pin_hold});
    $display("TB: hibernate test done");
    wb(1'b1, `PMC_ADR_MODE, 32'h2);
    wait_mode(PMC_SLEEP, 10);
    wk_u.pulse(8);
    act = 8'hFF;
    wait_mode(PMC_ACTIVE, 5);
    wb(1'b0, `PMC_ADR_STAT, 32'h0);
    chk("stat_reset", 32'h2, q & 32'h2);
    rd_chk("wake_en_rst", `PMC_ADR_WAKE_EN, 32'h3F);
    // a write without its low byte lane is acked but not stored
    sel <= 4'h0;
    wb(1'b1, `PMC_ADR_ACT_TPL, 32'h5A);
    sel <= 4'hF;
    rd_chk("sel_ignored", `PMC_ADR_ACT_TPL, 32'hFF);
    alt = 8'hFE;
    wb(1'b1, `PMC_ADR_MODE, 32'h1);
    wait_mode(PMC_ALT, 10);
    // watchdog reset and a status clear land on the same edge
    fork
      wk_u.pulse(6);
      wb(1'b1, `PMC_ADR_CLR, 32'h7);
    join
    wait_mode(PMC_ACTIVE, 5);
    rd_chk("stat_wdt", `PMC_ADR_STAT, 32'h2);
    $display("TB: reset pin test done");
    give_verdict();
  end
endmodule
